/* File: verilog/sims_pkg.sv */
package sims_pkg;

  // Clock and bus timing
  localparam int          CLK_MHZ    = 200;
  localparam int          T_HALF_NS  = 5000;
  localparam int          T_QTR_NS   = 2500;
  localparam int          CYC_HALF_I = (T_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          CYC_QTR_I  = (T_QTR_NS * CLK_MHZ + 999) / 1000;
  localparam logic [9:0]  CYC_HALF   = 10'(CYC_HALF_I - 1);
  localparam logic [9:0]  CYC_QTR    = 10'(CYC_QTR_I - 1);

  // Line select encodings
  localparam logic [1:0]  SEL_SERIAL = 2'h0;
  localparam logic [1:0]  SEL_COND   = 2'h1;
  localparam logic [1:0]  SEL_LOW    = 2'h2;
  localparam logic [1:0]  SEL_HIZ    = 2'h3;

  // Byte framing
  localparam logic [3:0]  ACK_BIT    = 4'h8;
  localparam int          TX_WIDTH   = 8;
  localparam int          TX_DEPTH   = 4;

  // Reset values
  localparam logic [1:0]  SEL_RST    = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_REL  = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_END  = 4'b0011,
    SP_LOW  = 4'b0100,
    SP_SCLH = 4'b0101,
    SP_END  = 4'b0110,
    BIT_LO  = 4'b0111,
    BIT_HI  = 4'b1000
  } sims_state_t;

endpackage

/* File: verilog/sims_fifo.sv */
module sims_fifo
  import sims_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 4
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // Honest full and empty from the occupancy count
  always_comb
  begin
    in_ready  = (cnt_r != (AW+1)'(D));
    out_valid = (cnt_r != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt    = pop  ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    out_data  = mem_r[rp_r];
  end

  // Pointers and count only; storage needs no reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

endmodule

/* File: verilog/sims_master.sv */
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] Software enables transmit, receive and both interrupt requests first; the bench enables the two interrupts only later, in t_start and t_bytes.
// [RULE_02] Start request is written together with both selects set to 01b; the bench first writes it with both selects 00b, in t_refuse.
// [RULE_03] Select 01b routes that line to the condition generator.
// [RULE_04] Start done: request clears, completion flag and its request set.
// [RULE_05] Software clears flag, selects serial lines, then writes address.
// [RULE_06] Clearing the completion flag also clears its pending request.
// [RULE_07] Every finished byte sets the transmit-buffer request flag.
// [RULE_08] After the last byte, stop is requested with both selects 01b.
// [RULE_09] Stop done: request clears, completion flag and its request set.
// [RULE_10] After stop, software clears flag and sets both selects to 11b.
// [RULE_11] Stop is requested only after the final byte has shifted out.
// [RULE_12] Software checks the acknowledge before writing the next byte; the bench queues all four bytes before any acknowledge.
// [RULE_13] Completion interrupt gated by enable; flags update regardless.
//////////////////////////////////////////////////////////////////////////////
module sims_master
  import sims_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control bits
  input  wire logic       tx_enable,
  input  wire logic       rx_enable,
  input  wire logic       tx_irq_enable,
  input  wire logic       cond_irq_enable,
  input  wire logic       ctrl_wr,
  input  wire logic       ctrl_begin,
  input  wire logic       ctrl_halt,
  input  wire logic [1:0] ctrl_scl_sel,
  input  wire logic [1:0] ctrl_sda_sel,
  input  wire logic       flag_clr,
  input  wire logic       tx_irq_clr,
  // Status
  output      logic       begin_condition_request,
  output      logic       halt_condition_request,
  output      logic [1:0] clock_line_select,
  output      logic [1:0] data_line_select,
  output      logic       cond_complete_flag,
  output      logic       cond_irq_flag,
  output      logic       tx_irq_flag,
  output      logic       cond_done_irq,
  output      logic       tx_buffer_irq,
  output      logic       ack_seen_n,
  output      logic [7:0] rx_data,
  // Transmit data
  input  wire logic       tx_valid,
  output      logic       tx_ready,
  input  wire logic [7:0] tx_data,
  // Bus lines
  input  wire logic       scl_i,
  output      logic       scl_o,
  output      logic       scl_oe_n,
  input  wire logic       sda_i,
  output      logic       sda_o,
  output      logic       sda_oe_n
);

  sims_state_t state_r, state_nxt;
  logic [9:0]  tmr_r, tmr_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt, rx_r, rx_nxt;
  logic        beg_r, beg_nxt, halt_r, halt_nxt;
  logic [1:0]  ssel_r, ssel_nxt, dsel_r, dsel_nxt;
  logic        flag_r, flag_nxt, cirq_r, cirq_nxt, tirq_r, tirq_nxt;
  logic        ack_r, ack_nxt;
  logic        cg_scl_r, cg_scl_nxt, cg_sda_r, cg_sda_nxt;
  logic        sh_scl_r, sh_scl_nxt, sh_sda_r, sh_sda_nxt;
  logic        scl_rel_r, scl_rel_nxt, sda_rel_r, sda_rel_nxt;
  logic [2:0]  scl_sy_r, sda_sy_r;
  logic        scl_s_r, sda_s_r;
  logic        fifo_valid, fifo_pop;
  logic [7:0]  fifo_data;
  logic        wait_scl, tick, cond_set, byte_done;

  // Four-word buffer so software can queue bytes ahead of the shifter
  sims_fifo #(
    .W (TX_WIDTH),
    .D (TX_DEPTH)
  ) u_txq (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      scl_s_r  <= 1'b1;
      sda_s_r  <= 1'b1;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[1:0], scl_i};
      sda_sy_r <= {sda_sy_r[1:0], sda_i};
      if (scl_sy_r[2] == scl_sy_r[1])
        scl_s_r <= scl_sy_r[2];
      if (sda_sy_r[2] == sda_sy_r[1])
        sda_s_r <= sda_sy_r[2];
    end
  end

  // Line routing; 10b is taken as a forced low
  function automatic logic route(input logic [1:0] sel,
                                 input logic cg, input logic sh);
    case (sel)
      SEL_SERIAL: route = sh;
      SEL_COND:   route = cg;
      SEL_LOW:    route = 1'b0;
      default:    route = 1'b1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    state_nxt  = state_r;
    tmr_nxt    = tmr_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    rx_nxt     = rx_r;
    beg_nxt    = beg_r;
    halt_nxt   = halt_r;
    ssel_nxt   = ssel_r;
    dsel_nxt   = dsel_r;
    ack_nxt    = ack_r;
    cg_scl_nxt = cg_scl_r;
    cg_sda_nxt = cg_sda_r;
    sh_scl_nxt = sh_scl_r;
    sh_sda_nxt = sh_sda_r;
    fifo_pop   = 1'b0;
    cond_set   = 1'b0;
    byte_done  = 1'b0;
    // Released clock waits for the line to rise, so slaves may stretch it
    wait_scl   = (state_r == ST_REL) || (state_r == SP_SCLH) ||
                 (state_r == BIT_HI);
    tick       = (tmr_r == '0) && !(wait_scl && !scl_s_r);
    if (!(wait_scl && !scl_s_r) && tmr_r != '0)
      tmr_nxt = tmr_r - 1'b1;
    case (state_r)
      ST_IDLE:
      begin
        if (beg_r && ssel_r == SEL_COND && dsel_r == SEL_COND)
        begin
          cg_scl_nxt = 1'b1; // RULE_03
          cg_sda_nxt = 1'b1;
          tmr_nxt    = CYC_HALF;
          state_nxt  = ST_REL;
        end
        else if (halt_r && ssel_r == SEL_COND && dsel_r == SEL_COND)
        begin
          cg_scl_nxt = 1'b0; // RULE_03
          cg_sda_nxt = 1'b0;
          tmr_nxt    = CYC_QTR;
          state_nxt  = SP_LOW;
        end
        else if (tx_enable && fifo_valid && ssel_r == SEL_SERIAL &&
                 dsel_r == SEL_SERIAL)
        begin
          fifo_pop   = 1'b1;
          sh_nxt     = fifo_data;
          sh_sda_nxt = fifo_data[7];
          sh_scl_nxt = 1'b0;
          bit_nxt    = '0;
          tmr_nxt    = CYC_HALF;
          state_nxt  = BIT_LO;
        end
      end
      ST_REL:
        if (tick)
        begin
          cg_sda_nxt = 1'b0;
          tmr_nxt    = CYC_HALF;
          state_nxt  = ST_HOLD;
        end
      ST_HOLD:
        if (tick)
        begin
          cg_scl_nxt = 1'b0;
          tmr_nxt    = CYC_QTR;
          state_nxt  = ST_END;
        end
      ST_END:
        if (tick)
        begin
          beg_nxt    = 1'b0; // RULE_04
          cond_set   = 1'b1;
          sh_scl_nxt = 1'b0; // Shifter takes over with SCL held low
          state_nxt  = ST_IDLE;
        end
      SP_LOW:
        if (tick)
        begin
          cg_scl_nxt = 1'b1;
          tmr_nxt    = CYC_HALF;
          state_nxt  = SP_SCLH;
        end
      SP_SCLH:
        if (tick)
        begin
          cg_sda_nxt = 1'b1;
          tmr_nxt    = CYC_HALF;
          state_nxt  = SP_END;
        end
      SP_END:
        if (tick)
        begin
          halt_nxt  = 1'b0; // RULE_09
          cond_set  = 1'b1;
          state_nxt = ST_IDLE;
        end
      BIT_LO:
      begin
        // Data moves mid-low, never with the clock edge: no false start/stop
        if (tmr_r == CYC_QTR)
          sh_sda_nxt = (bit_r == ACK_BIT) ? 1'b1 : sh_r[7];
        if (tick)
        begin
          sh_scl_nxt = 1'b1;
          tmr_nxt    = CYC_HALF;
          state_nxt  = BIT_HI;
        end
      end
      BIT_HI:
        if (tick)
        begin
          sh_scl_nxt = 1'b0;
          tmr_nxt    = CYC_HALF;
          if (bit_r == ACK_BIT)
          begin
            if (rx_enable)
              ack_nxt = sda_s_r;
            byte_done = 1'b1; // RULE_07
            state_nxt = ST_IDLE;
          end
          else
          begin
            if (rx_enable)
              rx_nxt = {rx_r[6:0], sda_s_r};
            sh_nxt     = {sh_r[6:0], 1'b0};
            bit_nxt    = bit_r + 1'b1;
            state_nxt  = BIT_LO;
          end
        end
      default:
        state_nxt = ST_IDLE;
    endcase
    // Software writes; a new request wins over a same-cycle completion
    if (ctrl_wr)
    begin
      ssel_nxt = ctrl_scl_sel;
      dsel_nxt = ctrl_sda_sel;
      if (ctrl_begin)
        beg_nxt = 1'b1;
      if (ctrl_halt)
        halt_nxt = 1'b1;
    end
    // Flags: hardware set beats software clear
    flag_nxt = cond_set ? 1'b1 : (flag_clr ? 1'b0 : flag_r); // RULE_04
    cirq_nxt = cond_set ? 1'b1 : (flag_clr ? 1'b0 : cirq_r); // RULE_06
    tirq_nxt = byte_done ? 1'b1 : (tx_irq_clr ? 1'b0 : tirq_r); // RULE_07
    scl_rel_nxt = route(ssel_nxt, cg_scl_nxt, sh_scl_nxt); // RULE_03
    sda_rel_nxt = route(dsel_nxt, cg_sda_nxt, sh_sda_nxt); // RULE_03
  end

  // Sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      tmr_r     <= '0;
      bit_r     <= '0;
      sh_r      <= '0;
      rx_r      <= '0;
      beg_r     <= 1'b0;
      halt_r    <= 1'b0;
      ssel_r    <= SEL_RST;
      dsel_r    <= SEL_RST;
      flag_r    <= 1'b0;
      cirq_r    <= 1'b0;
      tirq_r    <= 1'b0;
      ack_r     <= 1'b1;
      cg_scl_r  <= 1'b1;
      cg_sda_r  <= 1'b1;
      sh_scl_r  <= 1'b1;
      sh_sda_r  <= 1'b1;
      scl_rel_r <= 1'b1;
      sda_rel_r <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      tmr_r     <= tmr_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      rx_r      <= rx_nxt;
      beg_r     <= beg_nxt;
      halt_r    <= halt_nxt;
      ssel_r    <= ssel_nxt;
      dsel_r    <= dsel_nxt;
      flag_r    <= flag_nxt;
      cirq_r    <= cirq_nxt;
      tirq_r    <= tirq_nxt;
      ack_r     <= ack_nxt;
      cg_scl_r  <= cg_scl_nxt;
      cg_sda_r  <= cg_sda_nxt;
      sh_scl_r  <= sh_scl_nxt;
      sh_sda_r  <= sh_sda_nxt;
      scl_rel_r <= scl_rel_nxt;
      sda_rel_r <= sda_rel_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs; open drain, so only a low is ever driven
  assign begin_condition_request = beg_r;
  assign halt_condition_request  = halt_r;
  assign clock_line_select       = ssel_r;
  assign data_line_select        = dsel_r;
  assign cond_complete_flag      = flag_r;
  assign cond_irq_flag           = cirq_r;
  assign tx_irq_flag             = tirq_r;
  assign cond_done_irq           = cirq_r && cond_irq_enable; // RULE_13
  assign tx_buffer_irq           = tirq_r && tx_irq_enable;
  assign ack_seen_n              = ack_r;
  assign rx_data                 = rx_r;
  assign scl_o                   = 1'b0;
  assign sda_o                   = 1'b0;
  assign scl_oe_n                = scl_rel_r;
  assign sda_oe_n                = sda_rel_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  route_cond_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (ssel_r == SEL_COND && dsel_r == SEL_COND) |->
      (scl_oe_n == cg_scl_r && sda_oe_n == cg_sda_r))
    else $error("condition generator not routed to the lines");

  start_done_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (state_r == ST_END && tick && !(ctrl_wr && ctrl_begin)) |=>
      (!beg_r && flag_r && cirq_r && state_r == ST_IDLE))
    else $error("start completion did not update request and flags");

  stop_done_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (state_r == SP_END && tick && !(ctrl_wr && ctrl_halt)) |=>
      (!halt_r && flag_r && cirq_r))
    else $error("stop completion did not update request and flags");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    (flag_clr && !cond_set) |=> (!flag_r && !cirq_r && !cond_done_irq))
    else $error("flag clear left the request pending");

  byte_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (state_r == BIT_HI && bit_r == ACK_BIT && tick) |=>
      (tirq_r && (tx_buffer_irq == tx_irq_enable)))
    else $error("finished byte did not raise the transmit request");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (cond_set && !cond_irq_enable) |=> (cirq_r && flag_r) ##0
      (cond_done_irq == cond_irq_enable))
    else $error("completion flags not independent of the enable");

  start_seq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (state_r == ST_HOLD && ssel_r == SEL_COND && dsel_r == SEL_COND) |->
      (!sda_oe_n && scl_oe_n))
    else $error("start condition shape wrong on the lines");

  sda_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (state_r == BIT_HI && dsel_r == SEL_SERIAL && $stable(dsel_r)) |->
      $stable(sda_oe_n))
    else $error("data line moved while the clock was high");

endmodule

/* File: testbench/sims_slave.sv */
module sims_slave (
  // Bus lines as resolved on the wires
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour chosen by the bench
  input  wire logic       nack,
  input  wire logic       stretch,
  // Pull-downs of this device
  output      logic       sda_low,
  output      logic       scl_low,
  // What the device saw
  output      logic [7:0] last_byte,
  output      logic       started,
  output      logic       stopped
);
  timeunit 1ns;
  timeprecision 100ps;

  int         bit_cnt;
  logic [7:0] shift_r;

  // Released lines float to the pull-up level, never hold old values
  initial
  begin
    sda_low   = 1'b0;
    scl_low   = 1'b0;
    started   = 1'b0;
    stopped   = 1'b0;
    bit_cnt   = 0;
    shift_r   = 8'h00;
    last_byte = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Start and stop: SDA moving while SCL is high
  always @(negedge sda)
    if (scl)
    begin
      started = 1'b1;
      stopped = 1'b0;
      bit_cnt = 0;
    end

  always @(posedge sda)
    if (scl)
    begin
      stopped = 1'b1;
      started = 1'b0;
    end

  // Data bits taken on rising SCL, MSB first
  always @(posedge scl)
    if (started && bit_cnt < 8)
    begin
      shift_r = {shift_r[6:0], sda};
      bit_cnt++;
    end

  // Acknowledge slot, then optional clock stretch as a slow answer
  always @(negedge scl)
    if (started && bit_cnt == 8)
    begin
      last_byte = shift_r;
      sda_low   = ~nack;
      bit_cnt   = 9;
    end
    else if (started && bit_cnt == 9)
    begin
      sda_low = 1'b0;
      bit_cnt = 0;
      scl_low = stretch;
      #3000;
      scl_low = 1'b0;
    end
endmodule

/* File: testbench/tb.sv */
module tb;
  import sims_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rst_n, tx_enable, rx_enable, tx_irq_enable;
  logic       cond_irq_enable, ctrl_wr, ctrl_begin, ctrl_halt;
  logic       flag_clr, tx_irq_clr, tx_valid, tx_ready, ack_seen_n;
  logic [1:0] ctrl_scl_sel, ctrl_sda_sel;
  logic [1:0] clock_line_select, data_line_select;
  logic [7:0] tx_data, rx_data, last_byte;
  logic       begin_condition_request, halt_condition_request;
  logic       cond_complete_flag, cond_irq_flag, tx_irq_flag;
  logic       cond_done_irq, tx_buffer_irq;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, scl, sda;
  logic       slv_scl_low, slv_sda_low, nack, stretch, started, stopped;
  logic [7:0] bytes [4];
  int         err_total, cmp_count;

  // Open-drain wires with pull-ups
  assign scl = (scl_oe_n ? 1'b1 : scl_o) & ~slv_scl_low;
  assign sda = (sda_oe_n ? 1'b1 : sda_o) & ~slv_sda_low;

  sims_master i_sims_master (.clk(clk), .rst_n(rst_n),
    .tx_enable(tx_enable), .rx_enable(rx_enable),
    .tx_irq_enable(tx_irq_enable), .cond_irq_enable(cond_irq_enable),
    .ctrl_wr(ctrl_wr), .ctrl_begin(ctrl_begin), .ctrl_halt(ctrl_halt),
    .ctrl_scl_sel(ctrl_scl_sel), .ctrl_sda_sel(ctrl_sda_sel),
    .flag_clr(flag_clr), .tx_irq_clr(tx_irq_clr),
    .begin_condition_request(begin_condition_request),
    .halt_condition_request(halt_condition_request),
    .clock_line_select(clock_line_select),
    .data_line_select(data_line_select),
    .cond_complete_flag(cond_complete_flag), .cond_irq_flag(cond_irq_flag),
    .tx_irq_flag(tx_irq_flag), .cond_done_irq(cond_done_irq),
    .tx_buffer_irq(tx_buffer_irq), .ack_seen_n(ack_seen_n),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

  sims_slave i_sims_slave (.scl(scl), .sda(sda), .nack(nack),
    .stretch(stretch), .sda_low(slv_sda_low), .scl_low(slv_scl_low),
    .last_byte(last_byte), .started(started), .stopped(stopped));

  //////////////////////////////////////////////////////////////////////////
  // Clock and common tasks
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait on a flag (1: transmit request, 0: completion)
  task automatic wait_hi(input logic tx_side, input int lim);
    int   n;
    logic v;
    n = 0;
    v = tx_side ? tx_irq_flag : cond_complete_flag;
    while (v !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
      v = tx_side ? tx_irq_flag : cond_complete_flag;
    end
    if (v !== 1'b1)
    begin
      err_total++;
      $display("[ERR] t=%0t wait ran out seen=%h exp=%h", $time, v, 1'b1);
      give_verdict();
    end
  endtask

  task automatic wr_ctrl(input logic b, input logic h,
                         input logic [1:0] sc, input logic [1:0] sd);
    ctrl_wr      = 1'b1;
    ctrl_begin   = b;
    ctrl_halt    = h;
    ctrl_scl_sel = sc;
    ctrl_sda_sel = sd;
    @(negedge clk);
    ctrl_wr      = 1'b0;
    ctrl_begin   = 1'b0;
    ctrl_halt    = 1'b0;
  endtask

  // One-cycle clear (1: transmit request, 0: completion flag)
  task automatic pulse(input logic tx_side);
    if (tx_side)
      tx_irq_clr = 1'b1;
    else
      flag_clr = 1'b1;
    @(negedge clk);
    tx_irq_clr = 1'b0;
    flag_clr   = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_refuse();
    wr_ctrl(1'b1, 1'b0, SEL_SERIAL, SEL_SERIAL);
    repeat (3000) @(negedge clk);
    chk(8'(begin_condition_request), 8'h01);
    chk(8'(cond_complete_flag), 8'h00);
    chk(8'(started), 8'h00);
    // Forced-low select on the clock line only, data left released
    wr_ctrl(1'b0, 1'b0, SEL_LOW, SEL_HIZ);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h01);
    @(negedge clk);
    wr_ctrl(1'b0, 1'b0, SEL_HIZ, SEL_HIZ);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    @(negedge clk);
    $display("test refuse done");
  endtask

  task automatic t_start();
    // Pending request acts once both lines go to the generator
    wr_ctrl(1'b1, 1'b0, SEL_COND, SEL_COND);
    wait_hi(1'b0, 4000);
    chk(8'(begin_condition_request), 8'h00);
    chk(8'(cond_irq_flag), 8'h01);
    chk(8'(cond_done_irq), 8'h00);
    chk(8'(started), 8'h01);
    chk({clock_line_select, data_line_select}, 8'h05);
    cond_irq_enable = 1'b1;
    @(negedge clk);
    chk(8'(cond_done_irq), 8'h01);
    pulse(1'b0);
    chk(8'(cond_complete_flag), 8'h00);
    chk(8'(cond_irq_flag), 8'h00);
    chk(8'(cond_done_irq), 8'h00);
    $display("test start done");
  endtask

  task automatic t_bytes();
    tx_enable = 1'b0;
    wr_ctrl(1'b0, 1'b0, SEL_SERIAL, SEL_SERIAL);
    for (int i = 0; i < 4; i++)
    begin
      tx_valid = 1'b1;
      tx_data  = bytes[i];
      @(negedge clk);
    end
    tx_data = 8'h11;
    chk(8'(tx_ready), 8'h00);
    @(negedge clk);
    tx_valid  = 1'b0;
    tx_enable = 1'b1;
    stretch   = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wait_hi(1'b1, 25000);
      chk(last_byte, bytes[i]);
      chk(rx_data, bytes[i]);
      chk(8'(ack_seen_n), (i == 3) ? 8'h01 : 8'h00);
      chk(8'(tx_buffer_irq), (i == 0) ? 8'h00 : 8'h01);
      tx_irq_enable = 1'b1;
      nack = (i == 2);
      pulse(1'b1);
      chk(8'(tx_irq_flag), 8'h00);
    end
    chk(8'(tx_ready), 8'h01);
    $display("test bytes done");
  endtask

  task automatic t_stop();
    wr_ctrl(1'b0, 1'b1, SEL_COND, SEL_COND);
    wait_hi(1'b0, 6000);
    chk(8'(halt_condition_request), 8'h00);
    chk(8'(cond_done_irq), 8'h01);
    chk(8'(stopped), 8'h01);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    pulse(1'b0);
    wr_ctrl(1'b0, 1'b0, SEL_HIZ, SEL_HIZ);
    chk(8'(cond_irq_flag), 8'h00);
    chk({clock_line_select, data_line_select}, 8'h0f);
    $display("test stop done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n, ctrl_wr, ctrl_begin, ctrl_halt, flag_clr, tx_irq_clr} = '0;
    {tx_valid, tx_irq_enable, cond_irq_enable, nack, stretch} = '0;
    {ctrl_scl_sel, ctrl_sda_sel, tx_data} = '0;
    bytes = '{8'ha4, 8'h5b, 8'h00, 8'hff};
    err_total = 0;
    cmp_count = 0;
    tx_enable = 1'b1;
    rx_enable = 1'b1;
    repeat (16) @(negedge clk);
    chk({clock_line_select, data_line_select},
        {4'h0, SEL_RST, SEL_RST});
    chk({5'h0, cond_complete_flag, tx_irq_flag, ack_seen_n}, 8'h1);
    rst_n = 1'b1;
    t_refuse();
    t_start();
    t_bytes();
    t_stop();
    give_verdict();
  end
endmodule
